// File: bench/pfb_drive_model.sv
/*
  Far-side model for the pfb bench: PWM time base and the fault B source.
  Assumes the bench clock and a synchronous, active-high reset.
*/
`timescale 1ns/1ps
module pfb_drive_model #(
  parameter int PERIOD = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fault request from the bench
  input wire logic fault_req_i,
  // Time base and fault pin towards the block
  output logic [15:0] count_o,
  output logic boundary_o,
  output logic fault_b_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i || count_o == 16'(PERIOD - 1)) begin
      count_o <= 16'h0000;
    end else begin
      count_o <= count_o + 16'h0001;
    end
  end
  // Pulse while the count sits at zero, once each period
  assign boundary_o = (count_o == 16'h0000) && !rst_i;
  // Plain level: synchronising is the block's job
  assign fault_b_o = fault_req_i;
endmodule : pfb_drive_model

// File: bench/tb_pwm_fault_b_override_duty.sv
/*
  Self-checking bench for pfb_core: register table, overrides, fault B, duty.
  Assumes pfb_pkg offsets and the drive model for time base and fault pin.
*/
`timescale 1ns/1ps
module tb_pwm_fault_b_override_duty import pfb_pkg::*;;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [31:0] wd;
    logic [31:0] exp;
  } pfb_tb_row_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic fault_req = 1'b0;
  logic [7:0] fa_mask = 8'h00;
  logic [7:0] fa_val = 8'h00;
  pfb_wb_req_type q = '0;
  logic ack;
  logic [31:0] rdat;
  logic [15:0] tb_count;
  logic tb_bnd;
  logic fault_b;
  logic [7:0] pins;
  logic [31:0] r;
  int failures = 0;
  int cmp_count = 0;
  pfb_tb_row_type rows [16] = '{
    '{0, PFB_OFS_FLTB, 0, 32'h0}, '{0, PFB_OFS_OVRD, 0, 32'hff00},
    '{0, PFB_OFS_DUTY1, 0, 32'h0}, '{0, PFB_OFS_DUTY2, 0, 32'h0},
    '{0, PFB_OFS_DUTY3, 0, 32'h0}, '{0, PFB_OFS_DUTY4, 0, 32'h0},
    '{0, PFB_OFS_CTRL, 0, 32'h0}, '{1, PFB_OFS_FLTB, 32'hffff, 32'hff8f},
    '{1, PFB_OFS_FLTB, 0, 32'h0}, '{1, PFB_OFS_DUTY3, 32'habcd, 32'habcd},
    '{1, PFB_OFS_DUTY3, 0, 32'h0}, '{1, PFB_OFS_OVRD, 32'h1234, 32'h1234},
    '{1, PFB_OFS_OVRD, 32'hff00, 32'hff00}, '{1, PFB_OFS_CTRL, 32'hffff, 32'h6},
    '{1, PFB_OFS_CTRL, 0, 32'h0}, '{1, 8'h20, 32'hbeef, 32'h0}};

  always #2 clk_i = ~clk_i;

  pfb_core pfb_core_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(q.cyc), .wb_stb_i(q.stb), .wb_we_i(q.we), .wb_sel_i(q.sel),
    .wb_adr_i(q.adr), .wb_dat_i(q.dat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .tb_count_i(tb_count), .tb_boundary_i(tb_bnd), .fault_a_pin_mask_i(fa_mask),
    .fault_a_pin_value_i(fa_val), .fault_b_pin_i(fault_b), .pwm_pin_o(pins));
  pfb_drive_model pfb_drive_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .fault_req_i(fault_req), .count_o(tb_count), .boundary_o(tb_bnd),
    .fault_b_o(fault_b));

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Classic cycle: hold everything until ack is sampled, then one idle cycle
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] rd);
    int n;
    n = 0;
    q <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    q.cyc <= 1'b0;
    q.stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 50) failures++;
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, r);
  endtask : wr
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task bnd;
    for (int k = 0; k < 200 && tb_bnd !== 1'b1; k++) @(posedge clk_i);
    @(posedge clk_i);
  endtask : bnd
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : chk32
  task chkp(input logic [7:0] exp);
    cmp_count++;
    if (pins !== exp) begin
      failures++;
      $display("Error %0t: pins %h, expected %h", $time, pins, exp);
    end
  endtask : chkp

  initial begin
    #40000;
    failures++;
    report_and_stop();
  end

  initial begin
    cyc(8);
    rst_i <= 1'b0;
    cyc(1);
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].adr, rows[i].wd);
      wb(1'b0, rows[i].adr, 32'h0, r);
      chk32(r, rows[i].exp);
    end
    cyc(3);
    chkp(8'h55);
    wr(PFB_OFS_OVRD, 32'h00a5);
    cyc(3);
    chkp(8'ha5);
    wr(PFB_OFS_OVRD, 32'hf05a);
    cyc(3);
    chkp(8'h5a);
    wr(PFB_OFS_OVRD, 32'hff00);
    // Latched mode: pairs 1 and 2 only, values hold after the pin clears
    wr(PFB_OFS_FLTB, 32'h3c03);
    fault_req <= 1'b1;
    cyc(5);
    chkp(8'h5c);
    fault_req <= 1'b0;
    cyc(6);
    chkp(8'h5c);
    wr(PFB_OFS_FLTB, 32'h3c03);
    cyc(3);
    chkp(8'h55);
    // Cycle-by-cycle mode, with fault A taking pair 1
    wr(PFB_OFS_FLTB, 32'h3c83);
    fault_req <= 1'b1;
    fa_mask <= 8'h03;
    fa_val <= 8'h03;
    cyc(5);
    chkp(8'h5f);
    fault_req <= 1'b0;
    fa_mask <= 8'h00;
    cyc(6);
    chkp(8'h55);
    wr(PFB_OFS_FLTB, 32'h0);
    wr(PFB_OFS_CTRL, 32'h2);
    bnd();
    wr(PFB_OFS_OVRD, 32'h00ff);
    chkp(8'h55);
    bnd();
    cyc(3);
    chkp(8'hff);
    wr(PFB_OFS_OVRD, 32'hff00);
    bnd();
    wr(PFB_OFS_CTRL, 32'h0);
    bnd();
    wr(PFB_OFS_DUTY1, 32'h0020);
    chkp(8'h55);
    bnd();
    cyc(3);
    chkp(8'h56);
    while (tb_count !== 16'h0028) @(posedge clk_i);
    cyc(3);
    chkp(8'h55);
    wr(PFB_OFS_CTRL, 32'h4);
    wr(PFB_OFS_DUTY1, 32'h0);
    wr(PFB_OFS_DUTY4, 32'hffff);
    cyc(2);
    chkp(8'h95);
    // Enable low freezes the pins although fault A asks for all of them
    ce <= 1'b0;
    fa_mask <= 8'hff;
    fa_val <= 8'h00;
    cyc(3);
    chkp(8'h95);
    ce <= 1'b1;
    cyc(2);
    chkp(8'h00);
    fa_mask <= 8'h00;
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    cyc(1);
    wb(1'b0, PFB_OFS_OVRD, 32'h0, r);
    chk32(r, 32'hff00);
    wb(1'b0, PFB_OFS_DUTY4, 32'h0, r);
    chk32(r, 32'h0);
    report_and_stop();
  end
endmodule : tb_pwm_fault_b_override_duty

// File: src/pfb_core.sv
/*
  Secondary fault input, manual pin override and four duty-cycle registers
  of a four-generator PWM unit, with a classic Wishbone register slave.
  Assumes the time base count and its period-boundary pulse come from
  logic on the same clock; the fault B pin is asynchronous and synchronised here.
*/
// Overview of operation
// [RULE1] Fault B drives controlled pins to override values
// [RULE2] Mode 1: override only while fault present
// [RULE3] Mode 0: fault latches pins to override values
// [RULE4] Four pair enables put pairs under fault B
// [RULE5] Fault A wins over fault B
// [RULE6] Override-select 1 lets generator drive pin
// [RULE7] Override-select 0 drives pin from manual bit
// [RULE8] Manual bit gives pin level when selected
// [RULE9] Reset: selects all 1, manual bits 0
// [RULE10] Reset: fault B bits 0, unused read 0
// [RULE11] Four 16-bit duty registers reset to zero
// [RULE12] Override sync bit aligns overrides to time base
// [RULE13] Immediate bit applies duty at once
// [RULE14] Active duty compared with time base count
`timescale 1ns/1ps
module pfb_core
  import pfb_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [PFB_ADDR_W-1:0] wb_adr_i,
  input wire logic [PFB_DATA_W-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [PFB_DATA_W-1:0] wb_dat_o,
  // Time base and fault A logic of the unit
  input wire logic [15:0] tb_count_i,
  input wire logic tb_boundary_i,
  input wire logic [7:0] fault_a_pin_mask_i,
  input wire logic [7:0] fault_a_pin_value_i,
  // External fault B pin, active high
  input wire logic fault_b_pin_i,
  // Pins: generator_high_output of pair n at bit 2n-1, low at 2n-2
  output logic [7:0] pwm_pin_o
);

  pfb_wb_req_type req;
  pfb_state_type st_reg;
  pfb_state_type st_next;
  logic [1:0] fltb_sync_reg;
  logic fault_b_now;
  logic [7:0] gen_pins;
  logic [7:0] fltb_pin_mask;
  logic [31:0] wmask;
  logic wr_hit;
  logic rd_ack;
  logic fltb_active;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  // Two flops before the fault pin reaches any logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fltb_sync_reg <= 2'h0;
    end else if (ce_i) begin
      fltb_sync_reg <= {fltb_sync_reg[0], fault_b_pin_i};
    end
  end
  assign fault_b_now = fltb_sync_reg[1];

  assign wmask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
  assign wr_hit = req.cyc && req.stb && req.we && !st_reg.ack;
  assign rd_ack = req.cyc && req.stb && !st_reg.ack;

  // Per generator: output active while count is below the active duty
  generate
    for (genvar g = 0; g < PFB_NUM_GEN; g++) begin : g_cmp
      assign gen_pins[2*g+1] = tb_count_i < st_reg.duty_act[g]; // [RULE14]
      assign gen_pins[2*g] = !(tb_count_i < st_reg.duty_act[g]);
      assign fltb_pin_mask[2*g+1] = st_reg.fltb[g]; // [RULE4]
      assign fltb_pin_mask[2*g] = st_reg.fltb[g];
    end
  endgenerate

  // Fault B acts while latched in latched mode, or while present in cycle-by-cycle mode
  assign fltb_active = st_reg.fltb[PFB_FLTB_MODE_BIT] ? fault_b_now // [RULE2]
                                                       : st_reg.fltb_latch; // [RULE3]

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] m);
    merge16 = (old & ~m) | (nw & m);
  endfunction : merge16

  always_comb begin
    logic [7:0] pin_val;
    pin_val = 8'h00;
    st_next = st_reg;
    st_next.ack = rd_ack;
    st_next.rdat = st_reg.rdat;

    // Register writes take effect in the cycle ack is raised
    if (wr_hit) begin
      case (req.adr)
        PFB_OFS_FLTB:
          st_next.fltb = merge16(st_reg.fltb, req.dat[15:0],
                                 wmask[15:0] & PFB_FLTB_WMASK); // [RULE10]
        PFB_OFS_OVRD: st_next.ovrd = merge16(st_reg.ovrd, req.dat[15:0], wmask[15:0]);
        PFB_OFS_DUTY1: st_next.duty[0] = merge16(st_reg.duty[0], req.dat[15:0], wmask[15:0]);
        PFB_OFS_DUTY2: st_next.duty[1] = merge16(st_reg.duty[1], req.dat[15:0], wmask[15:0]);
        PFB_OFS_DUTY3: st_next.duty[2] = merge16(st_reg.duty[2], req.dat[15:0], wmask[15:0]);
        PFB_OFS_DUTY4: st_next.duty[3] = merge16(st_reg.duty[3], req.dat[15:0], wmask[15:0]);
        PFB_OFS_CTRL:
          st_next.ctrl = merge16(st_reg.ctrl, req.dat[15:0], wmask[15:0] & PFB_CTRL_WMASK);
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end

    if (rd_ack && !req.we) begin
      case (req.adr)
        PFB_OFS_FLTB: st_next.rdat = {16'h0000, st_reg.fltb};
        PFB_OFS_OVRD: st_next.rdat = {16'h0000, st_reg.ovrd};
        PFB_OFS_DUTY1: st_next.rdat = {16'h0000, st_reg.duty[0]};
        PFB_OFS_DUTY2: st_next.rdat = {16'h0000, st_reg.duty[1]};
        PFB_OFS_DUTY3: st_next.rdat = {16'h0000, st_reg.duty[2]};
        PFB_OFS_DUTY4: st_next.rdat = {16'h0000, st_reg.duty[3]};
        PFB_OFS_CTRL: st_next.rdat = {16'h0000, st_reg.ctrl};
        // Status word: latch at bit 24, active override at 23:8, pins at 7:0
        PFB_OFS_STAT: st_next.rdat = {7'h00, st_reg.fltb_latch, st_reg.ovrd_act,
                                      st_reg.pins};
        default: st_next.rdat = PFB_RD_UNMAPPED;
      endcase
    end

    // Latched fault: set wins over clear; a mode or enable rewrite releases it
    if (fault_b_now) begin
      st_next.fltb_latch = 1'b1; // [RULE3]
    end else if (wr_hit && req.adr == PFB_OFS_FLTB && req.sel[0]) begin
      st_next.fltb_latch = 1'b0;
    end

    // Override changes either now or at the period boundary
    if (!st_reg.ctrl[PFB_CTRL_OVERRIDE_SYNC_SELECT_BIT] || tb_boundary_i) begin
      st_next.ovrd_act = st_reg.ovrd; // [RULE12]
    end

    if (st_reg.ctrl[PFB_CTRL_IUE_BIT] || tb_boundary_i) begin
      st_next.duty_act = st_reg.duty; // [RULE13]
    end

    // Output priority: fault A, then fault B, then override, then generator
    for (int p = 0; p < PFB_NUM_PIN; p++) begin
      if (fault_a_pin_mask_i[p]) begin
        pin_val[p] = fault_a_pin_value_i[p]; // [RULE5]
      end else if (fltb_active && fltb_pin_mask[p]) begin
        pin_val[p] = st_reg.fltb[8+p]; // [RULE1]
      end else if (st_reg.ovrd_act[8+p]) begin
        pin_val[p] = gen_pins[p]; // [RULE6]
      end else begin
        pin_val[p] = st_reg.ovrd_act[p]; // [RULE7] [RULE8]
      end
    end
    st_next.pins = pin_val;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.fltb <= PFB_FLTB_RST; // [RULE10]
      st_reg.ovrd <= PFB_OVRD_RST; // [RULE9]
      st_reg.ovrd_act <= PFB_OVRD_RST;
      st_reg.duty <= {PFB_NUM_GEN{PFB_DUTY_RST}}; // [RULE11]
      st_reg.duty_act <= {PFB_NUM_GEN{PFB_DUTY_RST}};
      st_reg.ctrl <= PFB_CTRL_RST;
      st_reg.fltb_latch <= 1'b0;
      st_reg.pins <= 8'h00;
      st_reg.ack <= 1'b0;
      st_reg.rdat <= 32'h0000_0000;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdat;
  assign pwm_pin_o = st_reg.pins;

  a_reset_ovrd: assert property (@(posedge clk_i) $past(rst_i) |-> // [RULE9]
    st_reg.ovrd == 16'hff00 && st_reg.duty == '0)
    else $error("override or duty not at reset value");
  a_reset_fltb: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    st_reg.fltb[6:4] == 3'h0)
    else $error("unimplemented fault B bits set");
  a_fltb_drive: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    ce_i && fltb_active && st_reg.fltb[0] && !fault_a_pin_mask_i[1] |=>
    pwm_pin_o[1] == $past(st_reg.fltb[9]))
    else $error("fault B pin value wrong");
  a_cbc_release: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    ce_i && st_reg.fltb[7] && !fault_b_now && !fault_a_pin_mask_i[1] &&
    st_reg.ovrd_act[9] |=> pwm_pin_o[1] == $past(gen_pins[1]))
    else $error("cycle mode fault held without fault");
  a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    ce_i && fault_b_now |=> st_reg.fltb_latch)
    else $error("fault B not latched");
  a_pair_exempt: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    ce_i && !st_reg.fltb[1] && !fault_a_pin_mask_i[2] && !st_reg.ovrd_act[10] |=>
    pwm_pin_o[2] == $past(st_reg.ovrd_act[2]))
    else $error("exempt pair disturbed by fault B");
  a_fault_a_wins: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    ce_i && fault_a_pin_mask_i[0] |=> pwm_pin_o[0] == $past(fault_a_pin_value_i[0]))
    else $error("fault A not given priority");
  a_gen_drive: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    ce_i && !fault_a_pin_mask_i[3] && !(fltb_active && st_reg.fltb[1]) &&
    st_reg.ovrd_act[11] |=> pwm_pin_o[3] == $past(gen_pins[3]))
    else $error("generator not driving pin");
  a_manual_drive: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    ce_i && !fault_a_pin_mask_i[4] && !(fltb_active && st_reg.fltb[2]) &&
    !st_reg.ovrd_act[12] |=> pwm_pin_o[4] == $past(st_reg.ovrd_act[4])) // [RULE8]
    else $error("manual value not driving pin");
  a_duty_width: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    ce_i && wr_hit && req.adr == PFB_OFS_DUTY2 && req.sel[1:0] == 2'h3 |=>
    st_reg.duty[1] == $past(req.dat[15:0]))
    else $error("duty write lost");
  a_override_sync_select_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
    ce_i && st_reg.ctrl[1] && !tb_boundary_i |=> $stable(st_reg.ovrd_act))
    else $error("override applied off boundary");
  a_iue_now: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    ce_i && st_reg.ctrl[2] |=> st_reg.duty_act == $past(st_reg.duty))
    else $error("immediate duty not applied");
  a_compare: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
    ce_i && !fault_a_pin_mask_i[1] && !(fltb_active && st_reg.fltb[0]) &&
    st_reg.ovrd_act[9] |=> pwm_pin_o[1] == $past(tb_count_i < st_reg.duty_act[0]))
    else $error("duty compare wrong");
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // Bus answer timing and read data
  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i > PFB_OFS_STAT
    |=> wb_dat_o == PFB_RD_UNMAPPED)
    else $error("unmapped read not zero");

  a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i != PFB_OFS_STAT
    |=> wb_dat_o[31:16] == 16'h0000)
    else $error("upper half of register word not zero");

  a_ctrl_unused: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.ctrl[15:3] == 13'h0000 && !st_reg.ctrl[0])
    else $error("unused control bits set");

  a_reset_rest: assert property (@(posedge clk_i) $past(rst_i) |-> // [RULE10]
    st_reg.fltb == PFB_FLTB_RST && st_reg.ctrl == PFB_CTRL_RST && !wb_ack_o)
    else $error("fault B or control not at reset value");

  // Latch clear against a fault in the same cycle
  a_latch_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    ce_i && !fault_b_now && wr_hit && wb_adr_i == PFB_OFS_FLTB && wb_sel_i[0]
    |=> !st_reg.fltb_latch)
    else $error("fault B latch not released");

  a_latch_set_wins: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    ce_i && fault_b_now && wr_hit && wb_adr_i == PFB_OFS_FLTB |=> st_reg.fltb_latch)
    else $error("clear won over fault");

  // Fault B and fault A on the fourth pair
  a_pair4_fltb: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    ce_i && fltb_active && st_reg.fltb[3] && !fault_a_pin_mask_i[6] |=>
    pwm_pin_o[6] == $past(st_reg.fltb[14]))
    else $error("fault B value wrong on pair four");

  a_fault_a_high: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    ce_i && fault_a_pin_mask_i[7] |=> pwm_pin_o[7] == $past(fault_a_pin_value_i[7]))
    else $error("fault A not given priority on high pin");

  a_manual_high: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    ce_i && !fault_a_pin_mask_i[7] && !(fltb_active && st_reg.fltb[3]) &&
    !st_reg.ovrd_act[15] |=> pwm_pin_o[7] == $past(st_reg.ovrd_act[7]))
    else $error("manual value not driving high pin");

  a_gen_low: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
    ce_i && !fault_a_pin_mask_i[0] && !(fltb_active && st_reg.fltb[0]) &&
    st_reg.ovrd_act[8] |=> pwm_pin_o[0] == !$past(tb_count_i < st_reg.duty_act[0]))
    else $error("low pin not complement of compare");

  // Transfer of the shadowed values to the active copies
  a_ovrd_now: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
    ce_i && !st_reg.ctrl[1] |=> st_reg.ovrd_act == $past(st_reg.ovrd))
    else $error("override not applied next cycle");

  a_duty_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    ce_i && !st_reg.ctrl[2] && !tb_boundary_i |=> $stable(st_reg.duty_act))
    else $error("duty applied off boundary");

  a_duty_transfer: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    ce_i && tb_boundary_i |=> st_reg.duty_act == $past(st_reg.duty))
    else $error("duty not transferred at boundary");

  // Clock enable low must freeze every register
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(st_reg) && $stable(fltb_sync_reg))
    else $error("state moved while enable low");

  c_latched: cover property (@(posedge clk_i) disable iff (rst_i)
    st_reg.fltb_latch && !st_reg.fltb[7] && |st_reg.fltb[3:0]);
  c_cbc: cover property (@(posedge clk_i) disable iff (rst_i)
    st_reg.fltb[7] && fault_b_now ##1 !fault_b_now);
  c_manual: cover property (@(posedge clk_i) disable iff (rst_i) st_reg.ovrd_act[15:8] != 8'hff);
  c_both_faults: cover property (@(posedge clk_i) disable iff (rst_i)
    fltb_active && |(fault_a_pin_mask_i & fltb_pin_mask));
  c_override_sync_select_apply: cover property (@(posedge clk_i) disable iff (rst_i)
    st_reg.ctrl[1] && tb_boundary_i && st_reg.ovrd != st_reg.ovrd_act);

endmodule : pfb_core

// File: src/pfb_pkg.sv
/*
  Package for the secondary-fault, pin-override and duty-cycle block.
  Holds register offsets, field positions, reset values and bus/state carriers.
  Assumes a 32-bit classic Wishbone bus with byte addressing.
*/
package pfb_pkg;

  localparam int unsigned PFB_ADDR_W = 8;
  localparam int unsigned PFB_DATA_W = 32;
  localparam int unsigned PFB_NUM_GEN = 4;
  localparam int unsigned PFB_NUM_PIN = 8;

  // Register byte offsets
  localparam logic [7:0] PFB_OFS_FLTB = 8'h00;
  localparam logic [7:0] PFB_OFS_OVRD = 8'h04;
  localparam logic [7:0] PFB_OFS_DUTY1 = 8'h08;
  localparam logic [7:0] PFB_OFS_DUTY2 = 8'h0c;
  localparam logic [7:0] PFB_OFS_DUTY3 = 8'h10;
  localparam logic [7:0] PFB_OFS_DUTY4 = 8'h14;
  localparam logic [7:0] PFB_OFS_CTRL = 8'h18;
  localparam logic [7:0] PFB_OFS_STAT = 8'h1c;

  // Field positions
  localparam int unsigned PFB_FLTB_MODE_BIT = 7;
  localparam int unsigned PFB_CTRL_OVERRIDE_SYNC_SELECT_BIT = 1;
  localparam int unsigned PFB_CTRL_IUE_BIT = 2;

  // Writable masks of the fault B and control registers
  localparam logic [15:0] PFB_FLTB_WMASK = 16'hff8f;
  localparam logic [15:0] PFB_CTRL_WMASK = 16'h0006;

  // Values after reset
  localparam logic [15:0] PFB_FLTB_RST = 16'h0000;
  localparam logic [15:0] PFB_OVRD_RST = 16'hff00;
  localparam logic [15:0] PFB_DUTY_RST = 16'h0000;
  localparam logic [15:0] PFB_CTRL_RST = 16'h0000;
  localparam logic [31:0] PFB_RD_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [PFB_ADDR_W-1:0] adr;
    logic [PFB_DATA_W-1:0] dat;
  } pfb_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [PFB_DATA_W-1:0] dat;
  } pfb_wb_rsp_type;

  typedef struct packed {
    logic [15:0] fltb;
    logic [15:0] ovrd;
    logic [15:0] ovrd_act;
    logic [3:0][15:0] duty;
    logic [3:0][15:0] duty_act;
    logic [15:0] ctrl;
    logic fltb_latch;
    logic [7:0] pins;
    logic ack;
    logic [31:0] rdat;
  } pfb_state_type;

endpackage : pfb_pkg
